// ==== hw/piwc_ctrl.sv ====
// Functional notes
// - grant only above every level in service
// - equal or lower request waits for return
// - higher level preempts; in-service tracked per level
// - global enable bit seven gates all servicing
// - main enable bits for six sources
// - pin enables also enable stop wake-up
// - aux enable bits for four sources
// - port-1 enable gates service and idle wake, not stop wake
// - per-pin port-1 change mask, reset clear
// - two-bit priority, 3 highest, 0 lowest
// - main priority pair bit positions
// - aux priority pair bit positions
// - pins 0/1 trigger type: level or fall
// - pin 0/1 flags set on fall, cleared on entry
// - pin 2 falling only, cleared on entry
// - port-1 flag on masked pin change
// - write zero clears flag, one keeps
// - refuse stop while enabled pin low
// - fixed vectors 0003 upward in steps 8
// - idle wake any enabled; stop wake pins only
// - after stop wake, enter only if enabled
//
// interrupt enable, priority, pin detection and wake logic
// assumes a classic Wishbone master and a core that pulses entry/return
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "piwc_map.svh"
module piwc_ctrl
    import piwc_pkg::*;
(
    // system
    input wire logic CLK,
    input wire logic SYS_RST,
    // wishbone slave
    input wire logic WB_CYC,
    input wire logic WB_STB,
    input wire logic WB_WE,
    input wire logic [7:0] WB_ADR,
    input wire logic [3:0] WB_SEL,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK,
    // pins
    input wire logic EXT_REQUEST_PIN_A,
    input wire logic EXT_REQUEST_PIN_B,
    input wire logic EXT_REQUEST_PIN_C,
    input wire logic [7:0] PORT1_PINS,
    // peripheral event pulses and level requests
    input wire logic TIMER0_EVT,
    input wire logic TIMER1_EVT,
    input wire logic SERIAL_REQ,
    input wire logic TIMER2_REQ,
    input wire logic TIMER3_EVT,
    input wire logic CONV_DONE_EVT,
    input wire logic TOUCH_DONE_EVT,
    input wire logic LOW_VOLTAGE,
    // core handshake
    input wire logic CORE_ENTRY,
    input wire logic CORE_RETURN,
    input wire logic STOP_REQ,
    output logic IRQ_VALID,
    output logic [7:0] IRQ_VECTOR,
    output logic IDLE_WAKE,
    output logic STOP_WAKE,
    output logic STOP_REFUSE
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers, two flops before any logic
logic [10:0] sync1, sync2, prev;
always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        sync1 <= 11'h7FF;
        sync2 <= 11'h7FF;
        prev <= 11'h7FF;
    end else begin
        sync1 <= {PORT1_PINS, EXT_REQUEST_PIN_C, EXT_REQUEST_PIN_B, EXT_REQUEST_PIN_A};
        sync2 <= sync1;
        prev <= sync2;
    end
end
logic [2:0] pin_lvl, pin_fall;
logic [7:0] p1_chg;
always_comb begin
    pin_lvl = sync2[2:0];
    pin_fall = prev[2:0] & ~sync2[2:0];
    p1_chg = prev[10:3] ^ sync2[10:3];
end

////////////////////////////////////////////////////////////////////////////////
// registers
logic [7:0] trig, p1mask, mainen, auxen, mplo, mphi, aplo, aphi;
logic [3:0] iflag;
logic tf3, adf, tkf;
logic [3:0] insvc;
logic [7:0] sel_vec;
piwc_bus_e bus_st;
logic [7:0] next_trig, next_p1mask, next_mainen, next_auxen;
logic [7:0] next_mplo, next_mphi, next_aplo, next_aphi;
logic [3:0] next_iflag;
logic next_tf3, next_adf, next_tkf;
logic [3:0] next_insvc;
logic [7:0] rd_byte;
logic wr_hit;
logic [7:0] wdat;
piwc_src_t req, ena;
piwc_lvl_t lvl [`PIWC_NSRC];
logic [3:0] win_idx;
piwc_lvl_t win_lvl;
logic win_ok;
logic [1:0] top_lvl;
logic svc_any;
logic wake_pin;

assign wr_hit = WB_CYC & WB_STB & WB_WE & WB_SEL[0] & (bus_st == PIWC_IDLE);
assign wdat = WB_DAT_I[7:0];

////////////////////////////////////////////////////////////////////////////////
// source table, index = vector slot, slot 6 unused
logic [`PIWC_NSRC-1:0] raw;
logic [`PIWC_NSRC-1:0] en_bit;
logic [`PIWC_NSRC-1:0] hi_bit, lo_bit;
always_comb begin
    raw[0] = trig[1] | (~trig[0] & ~pin_lvl[0]);
    raw[1] = trig[5];
    raw[2] = trig[3] | (~trig[2] & ~pin_lvl[1]);
    raw[3] = trig[7];
    raw[4] = SERIAL_REQ;
    raw[5] = TIMER2_REQ;
    raw[6] = 1'b0;
    raw[7] = tf3;
    raw[8] = iflag[1];
    raw[9] = iflag[2];
    raw[10] = adf | tkf;
    en_bit[0] = mainen[0];
    en_bit[1] = mainen[1];
    en_bit[2] = mainen[2];
    en_bit[3] = mainen[3];
    en_bit[4] = mainen[4];
    en_bit[5] = mainen[5];
    en_bit[6] = 1'b0;
    en_bit[7] = auxen[0];
    en_bit[8] = auxen[1];
    en_bit[9] = auxen[2];
    en_bit[10] = auxen[3];
    hi_bit[5:0] = mphi[5:0];
    lo_bit[5:0] = mplo[5:0];
    hi_bit[6] = 1'b0;
    lo_bit[6] = 1'b0;
    hi_bit[10:7] = aphi[3:0];
    lo_bit[10:7] = aplo[3:0];
end

genvar gi;
generate
    for (gi = 0; gi < `PIWC_NSRC; gi++) begin : g_src
        assign lvl[gi] = {hi_bit[gi], lo_bit[gi]};
        assign ena[gi] = mainen[`PIWC_GLOBAL_BIT] & en_bit[gi];
        assign req[gi] = raw[gi] & ena[gi];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// arbitration
always_comb begin
    win_ok = 1'b0;
    win_idx = 4'h0;
    win_lvl = 2'h0;
    for (int i = `PIWC_NSRC - 1; i >= 0; i--) begin
        if (req[i] && (!win_ok || lvl[i] >= win_lvl)) begin
            win_ok = 1'b1;
            win_idx = 4'(i);
            win_lvl = lvl[i];
        end
    end
    svc_any = |insvc;
    top_lvl = 2'h0;
    for (int l = 0; l < 4; l++) begin
        if (insvc[l]) begin
            top_lvl = 2'(l);
        end
    end
end

logic grant_ok;
// equal or lower waits for return
assign grant_ok = win_ok & (!svc_any | (win_lvl > top_lvl));

////////////////////////////////////////////////////////////////////////////////
// next state
always_comb begin
    next_trig = trig;
    next_p1mask = p1mask;
    next_mainen = mainen;
    next_auxen = auxen;
    next_mplo = mplo;
    next_mphi = mphi;
    next_aplo = aplo;
    next_aphi = aphi;
    next_iflag = iflag;
    next_tf3 = tf3;
    next_adf = adf;
    next_tkf = tkf;
    next_insvc = insvc;
    if (wr_hit) begin
        case (WB_ADR)
            `PIWC_OFS_TRIG: next_trig = wdat;
            `PIWC_OFS_P1MASK: next_p1mask = wdat;
            `PIWC_OFS_MAINEN: next_mainen = wdat & `PIWC_MAIN_MASK;
            `PIWC_OFS_AUXEN: next_auxen = wdat & `PIWC_AUX_MASK;
            `PIWC_OFS_MPLO: next_mplo = wdat & `PIWC_PRIO_MASK;
            `PIWC_OFS_MPHI: next_mphi = wdat & `PIWC_PRIO_MASK;
            `PIWC_OFS_APLO: next_aplo = wdat & `PIWC_APRIO_MASK;
            `PIWC_OFS_APHI: next_aphi = wdat & `PIWC_APRIO_MASK;
            `PIWC_OFS_FLAG: begin
                next_tf3 = tf3 & wdat[0];
                next_iflag[1] = iflag[1] & wdat[1];
                next_iflag[2] = iflag[2] & wdat[2];
                next_adf = adf & wdat[4];
                next_tkf = tkf & wdat[5];
            end
            default: begin
            end
        endcase
    end
    // hardware entry clears pin flags
    if (CORE_ENTRY && IRQ_VALID) begin
        // pin 0/1 and port-1 flags cleared on entry
        if (IRQ_VECTOR == `PIWC_VEC_BASE) begin
            next_trig[1] = 1'b0;
        end
        if (IRQ_VECTOR == `PIWC_VEC_BASE + 8'h10) begin
            next_trig[3] = 1'b0;
        end
        if (IRQ_VECTOR == `PIWC_VEC_BASE + 8'h40) begin
            next_iflag[1] = 1'b0;
        end
        // pin 2 flag cleared on entry
        if (IRQ_VECTOR == `PIWC_VEC_BASE + 8'h48) begin
            next_iflag[2] = 1'b0;
        end
    end
    if (CORE_RETURN) begin
        next_insvc[top_lvl] = 1'b0;
    end
    if (CORE_ENTRY && IRQ_VALID) begin
        next_insvc[lvl[IRQ_VECTOR[6:3]]] = 1'b1;
    end
    // sets applied last so an event beats a clear
    // falling edge sets regardless of enable
    if (pin_fall[0] && trig[0]) begin
        next_trig[1] = 1'b1;
    end
    if (pin_fall[1] && trig[2]) begin
        next_trig[3] = 1'b1;
    end
    if (pin_fall[2]) begin
        next_iflag[2] = 1'b1;
    end
    if (|(p1_chg & p1mask)) begin
        next_iflag[1] = 1'b1;
    end
    if (TIMER0_EVT) begin
        next_trig[5] = 1'b1;
    end
    if (TIMER1_EVT) begin
        next_trig[7] = 1'b1;
    end
    if (TIMER3_EVT) begin
        next_tf3 = 1'b1;
    end
    if (CONV_DONE_EVT) begin
        next_adf = 1'b1;
    end
    if (TOUCH_DONE_EVT) begin
        next_tkf = 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read mux and outputs
always_comb begin
    case (WB_ADR)
        `PIWC_OFS_TRIG: rd_byte = trig;
        `PIWC_OFS_FLAG: rd_byte = {LOW_VOLTAGE, 1'b0, tkf, adf, 1'b0, iflag[2:1], tf3};
        `PIWC_OFS_P1MASK: rd_byte = p1mask;
        `PIWC_OFS_MAINEN: rd_byte = mainen;
        `PIWC_OFS_AUXEN: rd_byte = auxen;
        `PIWC_OFS_MPLO: rd_byte = mplo;
        `PIWC_OFS_MPHI: rd_byte = mphi;
        `PIWC_OFS_APLO: rd_byte = aplo;
        `PIWC_OFS_APHI: rd_byte = aphi;
        `PIWC_OFS_STAT: rd_byte = {4'h0, insvc};
        `PIWC_OFS_VEC: rd_byte = sel_vec;
        default: rd_byte = `PIWC_RST_BYTE;
    endcase
end

logic [7:0] next_vec;
logic next_valid, next_iwake, next_swake, next_refuse;
always_comb begin
    // vector = 03 + 8 * slot
    next_vec = `PIWC_VEC_BASE + {1'b0, win_idx, 3'b000};
    // entry only when enabled, stop wake alone does not enter
    next_valid = grant_ok;
    // idle wake by any enabled request
    next_iwake = win_ok;
    // pin enables wake stop without global bit
    // port-1 wake ignores its irq enable
    wake_pin = (mainen[0] & ~pin_lvl[0]) | (mainen[2] & ~pin_lvl[1])
             | (auxen[2] & pin_fall[2]) | (|(p1_chg & p1mask));
    next_swake = wake_pin;
    // refuse stop while enabled pin low
    next_refuse = STOP_REQ & ((mainen[0] & ~pin_lvl[0]) | (mainen[2] & ~pin_lvl[1])
                | (auxen[2] & ~pin_lvl[2]));
end

always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        trig <= `PIWC_RST_BYTE;
        p1mask <= `PIWC_RST_BYTE;
        mainen <= `PIWC_RST_BYTE;
        auxen <= `PIWC_RST_BYTE;
        mplo <= `PIWC_RST_BYTE;
        mphi <= `PIWC_RST_BYTE;
        aplo <= `PIWC_RST_BYTE;
        aphi <= `PIWC_RST_BYTE;
        iflag <= 4'h0;
        tf3 <= 1'b0;
        adf <= 1'b0;
        tkf <= 1'b0;
        insvc <= 4'h0;
        sel_vec <= `PIWC_RST_BYTE;
        IRQ_VALID <= 1'b0;
        IRQ_VECTOR <= `PIWC_RST_BYTE;
        IDLE_WAKE <= 1'b0;
        STOP_WAKE <= 1'b0;
        STOP_REFUSE <= 1'b0;
    end else begin
        trig <= next_trig;
        p1mask <= next_p1mask;
        mainen <= next_mainen;
        auxen <= next_auxen;
        mplo <= next_mplo;
        mphi <= next_mphi;
        aplo <= next_aplo;
        aphi <= next_aphi;
        iflag <= next_iflag;
        tf3 <= next_tf3;
        adf <= next_adf;
        tkf <= next_tkf;
        insvc <= next_insvc;
        sel_vec <= next_vec;
        IRQ_VALID <= next_valid;
        IRQ_VECTOR <= next_vec;
        IDLE_WAKE <= next_iwake;
        STOP_WAKE <= next_swake;
        STOP_REFUSE <= next_refuse;
    end
end

////////////////////////////////////////////////////////////////////////////////
// wishbone: one wait state, ack for one cycle
piwc_bus_e next_bus;
logic [31:0] next_dat;
always_comb begin
    next_bus = PIWC_IDLE;
    next_dat = WB_DAT_O;
    if (bus_st == PIWC_IDLE && WB_CYC && WB_STB) begin
        next_bus = PIWC_ACK;
        next_dat = {24'h000000, rd_byte};
    end
end
always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
        bus_st <= PIWC_IDLE;
        WB_ACK <= 1'b0;
        WB_DAT_O <= 32'h00000000;
    end else begin
        bus_st <= next_bus;
        WB_ACK <= (next_bus == PIWC_ACK);
        WB_DAT_O <= next_dat;
    end
end

endmodule

// ==== hw/piwc_map.svh ====
// register offsets, field positions and reset values of the interrupt and wake controller
// assumes an 8-bit special-register space reached over a word-wide Wishbone slave
`ifndef PIWC_MAP_SVH
`define PIWC_MAP_SVH
`define PIWC_OFS_TRIG 8'h88
`define PIWC_OFS_FLAG 8'h95
`define PIWC_OFS_P1MASK 8'h96
`define PIWC_OFS_MAINEN 8'hA8
`define PIWC_OFS_AUXEN 8'hA9
`define PIWC_OFS_MPLO 8'hB8
`define PIWC_OFS_MPHI 8'hB9
`define PIWC_OFS_APLO 8'hBA
`define PIWC_OFS_APHI 8'hBB
`define PIWC_OFS_CTRL 8'hC0
`define PIWC_OFS_STAT 8'hC1
`define PIWC_OFS_VEC 8'hC2
`define PIWC_RST_BYTE 8'h00
`define PIWC_GLOBAL_BIT 7
`define PIWC_MAIN_MASK 8'hBF
`define PIWC_AUX_MASK 8'h0F
`define PIWC_PRIO_MASK 8'h3F
`define PIWC_APRIO_MASK 8'h0F
`define PIWC_FLAG_RMASK 8'hBF
`define PIWC_TRIG_RMASK 8'h55
`define PIWC_NSRC 11
`define PIWC_VEC_BASE 8'h03
`define PIWC_ICE_SLOT 6
`define PIWC_LVL_MAX 2'h3
`endif

// ==== hw/piwc_pkg.sv ====
// types of the interrupt and wake controller
// assumes the map header defines the source count
`include "piwc_map.svh"
package piwc_pkg;
    typedef logic [1:0] piwc_lvl_t;
    typedef logic [`PIWC_NSRC-1:0] piwc_src_t;
    typedef enum logic [1:0] {
        PIWC_IDLE = 2'b00,
        PIWC_ACK = 2'b01
    } piwc_bus_e;
endpackage

// ==== testbench/piwc_checker.sv ====
// port assertions for the interrupt and wake controller
// assumes a classic Wishbone master and a core that pulses entry
`timescale 1ns/10ps
module piwc_checker (
    // system
    input wire logic CLK,
    input wire logic SYS_RST,
    // bus
    input wire logic WB_CYC,
    input wire logic WB_STB,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK,
    // core side
    input wire logic CORE_ENTRY,
    input wire logic STOP_REQ,
    input wire logic IRQ_VALID,
    input wire logic [7:0] IRQ_VECTOR,
    input wire logic IDLE_WAKE,
    input wire logic STOP_REFUSE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    ////////////////////////////////////////////////////////////
    a_ack_pulse: assert property (WB_ACK |=> !WB_ACK)
        else $error("ack held over one cycle");
    a_ack_answer: assert property (WB_CYC && WB_STB && !WB_ACK |=> WB_ACK)
        else $error("request not acked on next edge");
    a_dat_upper: assert property (WB_ACK |-> WB_DAT_O[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    a_reset_quiet: assert property ($fell(SYS_RST) |-> !WB_ACK && !IRQ_VALID && !STOP_REFUSE)
        else $error("output active right after reset");
    a_vec_legal: assert property (
        IRQ_VALID |-> IRQ_VECTOR[2:0] == 3'h3 && IRQ_VECTOR <= 8'h53 && IRQ_VECTOR != 8'h33)
        else $error("vector outside the fixed table");
    // two edges for in-service to take hold, then the same vector must be gone
    a_entry_blocks: assert property (
        CORE_ENTRY && IRQ_VALID |=> ##1 (!IRQ_VALID || IRQ_VECTOR != $past(IRQ_VECTOR, 2)))
        else $error("entered vector granted again");
    a_wake_covers: assert property (IRQ_VALID |-> IDLE_WAKE)
        else $error("grant without idle wake");
    a_refuse_cause: assert property (STOP_REFUSE |-> $past(STOP_REQ))
        else $error("stop refused without a request");
endmodule

bind piwc_ctrl piwc_checker piwc_checker_inst (.CLK, .SYS_RST, .WB_CYC, .WB_STB, .WB_DAT_O,
    .WB_ACK, .CORE_ENTRY, .STOP_REQ, .IRQ_VALID, .IRQ_VECTOR, .IDLE_WAKE, .STOP_REFUSE);

// ==== testbench/piwc_core_model.sv ====
// behavioural core: enters the granted routine, returns on command
// assumes the bench raises take_en once per wanted entry
`timescale 1ns/10ps
module piwc_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // controller side
    input wire logic irq_valid,
    input wire logic [7:0] irq_vector,
    output logic core_entry,
    output logic core_return,
    // bench side
    input wire logic take_en,
    input wire logic ret_req,
    output logic [7:0] last_vec,
    output logic [2:0] depth
);
    logic done;
    // one entry per take window: valid needs two edges to settle after entry
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            core_entry <= 1'h0;
            core_return <= 1'h0;
            done <= 1'h0;
            depth <= 3'h0;
            last_vec <= 8'h00;
        end else begin
            core_entry <= take_en && irq_valid && !done && !core_entry;
            core_return <= ret_req && !core_return && depth != 3'h0;
            done <= take_en && (done || core_entry);
            depth <= depth + 3'(core_entry) - 3'(core_return);
            if (core_entry) begin
                last_vec <= irq_vector;
            end
        end
    end
endmodule

// ==== testbench/prio_interrupt_wake_ctrl_tb.sv ====
// self-checking bench for the interrupt and wake controller
// assumes the core model on the far side and a one-cycle bus ack
`timescale 1ns/10ps
module prio_interrupt_wake_ctrl_tb;
    logic CLK, SYS_RST, WB_CYC, WB_STB, WB_WE, WB_ACK, EXT_REQUEST_PIN_A, EXT_REQUEST_PIN_C;
    logic LOW_VOLTAGE, CORE_ENTRY, CORE_RETURN, STOP_REQ, IRQ_VALID, IDLE_WAKE;
    logic STOP_WAKE, STOP_REFUSE, take, ret, EXT_REQUEST_PIN_B;
    logic [7:0] WB_ADR, PORT1_PINS, IRQ_VECTOR, lastv, rd;
    logic [31:0] WB_DAT_I, WB_DAT_O;
    logic [6:0] ev;
    logic [2:0] depth;
    int num_errors, checks;

    piwc_ctrl piwc_ctrl_inst (.CLK, .SYS_RST, .WB_CYC, .WB_STB, .WB_WE, .WB_ADR,
        .WB_SEL(4'hF), .WB_DAT_I, .WB_DAT_O, .WB_ACK, .EXT_REQUEST_PIN_A,
        .EXT_REQUEST_PIN_B, .EXT_REQUEST_PIN_C, .PORT1_PINS, .TIMER0_EVT(ev[0]),
        .TIMER1_EVT(ev[1]), .SERIAL_REQ(ev[2]), .TIMER2_REQ(ev[3]), .TIMER3_EVT(ev[4]),
        .CONV_DONE_EVT(ev[5]), .TOUCH_DONE_EVT(ev[6]), .LOW_VOLTAGE, .CORE_ENTRY,
        .CORE_RETURN, .STOP_REQ, .IRQ_VALID, .IRQ_VECTOR, .IDLE_WAKE, .STOP_WAKE,
        .STOP_REFUSE);
    piwc_core_model piwc_core_model_inst (.clk(CLK), .rst(SYS_RST), .irq_valid(IRQ_VALID),
        .irq_vector(IRQ_VECTOR), .core_entry(CORE_ENTRY), .core_return(CORE_RETURN),
        .take_en(take), .ret_req(ret), .last_vec(lastv), .depth(depth));

    initial begin
        CLK = 1'h0;
        forever #5 CLK = ~CLK;
    end
    ////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (num_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cyc_n(input int n);
        repeat (n) @(posedge CLK);
    endtask

    // classic cycle: hold everything until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge CLK);
        WB_CYC <= 1'h1;
        WB_STB <= 1'h1;
        WB_WE <= w;
        WB_ADR <= a;
        WB_DAT_I <= {24'h0, d};
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (WB_ACK !== 1'h1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            $display("mismatch %0t bus ack timeout", $time);
        end
        rd = WB_DAT_O[7:0];
        WB_CYC <= 1'h0;
        WB_STB <= 1'h0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        wb(1'h0, a, 8'h00);
        chk(rd, e);
    endtask

    task automatic chkv(input logic v, input logic [7:0] e);
        chk({7'h0, IRQ_VALID}, {7'h0, v});
        if (v) begin
            chk(IRQ_VECTOR, e);
        end
    endtask

    task automatic enter;
        take <= 1'h1;
        cyc_n(4);
        take <= 1'h0;
    endtask

    task automatic leave;
        ret <= 1'h1;
        @(posedge CLK);
        ret <= 1'h0;
        cyc_n(3);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [15:0] tbl [9] = '{16'hA8BF, 16'hA90F, 16'hB83F, 16'hB93F, 16'hBA0F,
            16'hBB0F, 16'h96FF, 16'h9000, 16'hC000};
        foreach (tbl[i]) begin
            rdc(tbl[i][15:8], 8'h00);
            wb(1'h1, tbl[i][15:8], 8'hFF);
            rdc(tbl[i][15:8], tbl[i][7:0]);
            wb(1'h1, tbl[i][15:8], 8'h00);
        end
        rdc(8'h88, 8'h00);
        wb(1'h1, 8'h95, 8'hFF);
        rdc(8'h95, 8'h00);
        LOW_VOLTAGE <= 1'h1;
        cyc_n(3);
        rdc(8'h95, 8'h80);
        LOW_VOLTAGE <= 1'h0;
    endtask

    task automatic t_vec;
        logic [23:0] tbl [7] = '{24'h82000B, 24'h88001B, 24'h900023, 24'hA0002B,
            24'h80013B, 24'h800853, 24'h800853};
        for (int i = 0; i < 7; i++) begin
            wb(1'h1, 8'hA8, tbl[i][23:16]);
            wb(1'h1, 8'hA9, tbl[i][15:8]);
            ev <= 7'h01 << i;
            cyc_n(3);
            chkv(1'h1, tbl[i][7:0]);
            ev <= 7'h00;
            wb(1'h1, 8'h88, 8'h00);
            wb(1'h1, 8'h95, 8'h00);
            cyc_n(1);
            chkv(1'h0, 8'h00);
        end
        wb(1'h1, 8'hA9, 8'h00);
    endtask

    task automatic t_nest;
        ev <= 7'h03;
        @(posedge CLK);
        ev <= 7'h00;
        wb(1'h1, 8'hA8, 8'h0A);
        cyc_n(2);
        chkv(1'h0, 8'h00);
        chk({7'h0, IDLE_WAKE}, 8'h00);
        wb(1'h1, 8'hA8, 8'h8A);
        cyc_n(2);
        chkv(1'h1, 8'h0B);
        enter;
        chk(lastv, 8'h0B);
        chkv(1'h0, 8'h00);
        rdc(8'hC1, 8'h01);
        wb(1'h1, 8'hB9, 8'h08);
        wb(1'h1, 8'hB8, 8'h08);
        cyc_n(2);
        chkv(1'h1, 8'h1B);
        enter;
        rdc(8'hC1, 8'h09);
        wb(1'h1, 8'h88, 8'h00);
        leave;
        rdc(8'hC1, 8'h01);
        leave;
        rdc(8'hC1, 8'h00);
        wb(1'h1, 8'hA8, 8'h00);
        wb(1'h1, 8'hB9, 8'h00);
        wb(1'h1, 8'hB8, 8'h00);
    endtask

    task automatic t_pins;
        wb(1'h1, 8'hA8, 8'h84);
        EXT_REQUEST_PIN_B <= 1'h0;
        cyc_n(4);
        chkv(1'h1, 8'h13);
        EXT_REQUEST_PIN_B <= 1'h1;
        cyc_n(4);
        chkv(1'h0, 8'h00);
        wb(1'h1, 8'h88, 8'h01);
        EXT_REQUEST_PIN_A <= 1'h0;
        cyc_n(6);
        rdc(8'h88, 8'h03);
        EXT_REQUEST_PIN_A <= 1'h1;
        wb(1'h1, 8'hA8, 8'h81);
        cyc_n(2);
        chkv(1'h1, 8'h03);
        enter;
        rdc(8'h88, 8'h01);
        leave;
        wb(1'h1, 8'hA8, 8'h00);
        EXT_REQUEST_PIN_C <= 1'h0;
        PORT1_PINS <= 8'h02;
        cyc_n(6);
        rdc(8'h95, 8'h04);
        wb(1'h1, 8'h96, 8'h01);
        PORT1_PINS <= 8'h03;
        cyc_n(6);
        rdc(8'h95, 8'h06);
        wb(1'h1, 8'hA8, 8'h80);
        wb(1'h1, 8'hA9, 8'h06);
        cyc_n(2);
        chkv(1'h1, 8'h43);
        wb(1'h1, 8'h95, 8'hFD);
        rdc(8'h95, 8'h04);
        chkv(1'h1, 8'h4B);
        wb(1'h1, 8'h95, 8'hFB);
        rdc(8'h95, 8'h00);
        EXT_REQUEST_PIN_C <= 1'h1;
        wb(1'h1, 8'hA9, 8'h00);
        EXT_REQUEST_PIN_A <= 1'h0;
        STOP_REQ <= 1'h1;
        wb(1'h1, 8'hA8, 8'h01);
        cyc_n(4);
        chk({6'h0, STOP_REFUSE, STOP_WAKE}, 8'h03);
        wb(1'h1, 8'hA8, 8'h00);
        cyc_n(3);
        chk({6'h0, STOP_REFUSE, STOP_WAKE}, 8'h00);
        EXT_REQUEST_PIN_A <= 1'h1;
        STOP_REQ <= 1'h0;
        cyc_n(4);
        wb(1'h1, 8'h88, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        #200000;
        num_errors++;
        stop_test;
    end

    initial begin
        SYS_RST = 1'h1;
        {WB_CYC, WB_STB, WB_WE, LOW_VOLTAGE, STOP_REQ, take, ret} = 7'h00;
        WB_ADR = 8'h00;
        WB_DAT_I = 32'h0;
        EXT_REQUEST_PIN_A = 1'h1;
        EXT_REQUEST_PIN_C = 1'h1;
        EXT_REQUEST_PIN_B = 1'h1;
        PORT1_PINS = 8'h00;
        ev = 7'h00;
        num_errors = 0;
        checks = 0;
        repeat (16) @(posedge CLK);
        SYS_RST <= 1'h0;
        t_regs;
        t_vec;
        t_nest;
        t_pins;
        stop_test;
    end
endmodule
